// ===== shared/sfr_bank_regs.svh
`ifndef SFR_BANK_REGS_SVH
`define SFR_BANK_REGS_SVH

// Register offsets on the microcontroller special-function bus
`define PIN_EVENT_MASK_ADDR    8'h9C
`define UTILITY_SETUP_ADDR     8'h9D
`define BUFFER_DATA_PORT_ADDR  8'h9F
`define BUFFER_ADDR_LOW_ADDR   8'hA1
`define BUFFER_ADDR_HIGH_ADDR  8'hA2
// Address of the pin event flag register, reached on the same bus
`define PIN_EVENT_FLAG_ADDR    8'h9B

// Reset values
`define PIN_EVENT_MASK_RESET   8'hFF
`define UTILITY_SETUP_RESET    8'h00

// Field positions in utility_setup
`define SCRATCH_MAP_BIT        7
`define RESERVED_BIT           6
`define LED_BLINK_BIT          5
`define PIN4_STROBE_BIT        4
`define TIMER1_SRC_BIT         3
`define TIMER0_SRC_BIT         2
`define PIN1_TX_BIT            1
`define RX_SRC_BIT             0

// Buffer address layout
`define BUF_ADDR_W             11
`define BUF_HIGH_W             3

// Blink half period: 500 ms expressed in nanoseconds, clock period 8 ns
`define BLINK_HALF_NS          500000000
`define CLK_PERIOD_NS          8

`endif

// ===== shared/sfr_bank_pkg.sv
package sfr_bank_pkg;
  typedef logic [7:0]  sfr_byte_t;
  typedef logic [10:0] buf_addr_t;
endpackage

// ===== core/buffer_ram.sv
module buffer_ram #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [AW-1:0] raddr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array; read data is registered
  // Separate write and read addresses let the owner prefetch the next byte
  // while a write lands; a read of the byte being written returns old data.
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // buffer_ram

// ===== core/mcu_utility_sfr_bank.sv
// Overview of operation
// - Mask bit 1 blocks its pin event flag
// - Interrupt high when any unmasked flag set
// - Write one clears flag, rearms detection
// - Map select chooses code or data space
// - Auto blink toggles pin 0 while pin 0 is an output, 1 s
// - Bit 4 puts write strobe on pin 4
// - Bit 3 zero feeds pin 3 timer1
// - Bit 2 zero feeds pin 2 timer0
// - Bit 1 puts serial transmit on pin 1
// - Bit 0 selects pin 0 or zero receive
// - Data port write stores byte at address
// - Data port read returns addressed byte
// - Auto-incremented accesses need no delay
// - Eleven bit address, low and high registers
// - High register bits 7..3 read zero
// - Address increments after each data access
`include "sfr_bank_regs.svh"

module mcu_utility_sfr_bank #(
  parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_NS / `CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic [7:0]  pin_event_set,
  output logic             core_external_irq_line,
  output logic             scratch_map_select,
  output logic             external_data_space,
  input  wire logic        general_pin_0_in,
  input  wire logic        general_pin_2_in,
  input  wire logic        general_pin_3_in,
  input  wire logic        general_pin_0_out,
  input  wire logic        general_pin_0_oe_n,
  input  wire logic        general_pin_1_out,
  input  wire logic        general_pin_4_out,
  input  wire logic        disk_io_write_strobe,
  input  wire logic        port3_bit1,
  input  wire logic        timer0_alt_src,
  input  wire logic        timer1_alt_src,
  output logic             port3_bit0,
  output logic             timer0_count_in,
  output logic             timer1_count_in,
  output logic             pin0_drive,
  output logic             pin1_drive,
  output logic             pin4_drive,
  output logic [7:0]       pin_event_flags
);
  localparam int CW = $clog2(BLINK_HALF_CYCLES + 1);

  // Pin synchronisers: first stage read only by the second
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else if (ce) begin
      pin_s1_r <= {general_pin_3_in, general_pin_2_in, general_pin_0_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic                   wr_mask;
  logic                   wr_setup;
  logic                   wr_flag;
  logic                   wr_low;
  logic                   wr_high;
  logic                   data_acc;
  logic                   data_wr;

  always_comb begin
    wr_mask  = 1'b0;
    wr_setup = 1'b0;
    wr_flag  = 1'b0;
    wr_low   = 1'b0;
    wr_high  = 1'b0;
    data_acc = 1'b0;
    data_wr  = 1'b0;
    if (sfr_addr == `PIN_EVENT_MASK_ADDR) begin
      wr_mask = sfr_wr;
    end else if (sfr_addr == `UTILITY_SETUP_ADDR) begin
      wr_setup = sfr_wr;
    end else if (sfr_addr == `PIN_EVENT_FLAG_ADDR) begin
      wr_flag = sfr_wr;
    end else if (sfr_addr == `BUFFER_ADDR_LOW_ADDR) begin
      wr_low = sfr_wr;
    end else if (sfr_addr == `BUFFER_ADDR_HIGH_ADDR) begin
      wr_high = sfr_wr;
    end else if (sfr_addr == `BUFFER_DATA_PORT_ADDR) begin
      data_acc = sfr_wr | sfr_rd;
      data_wr  = sfr_wr;
    end
  end

  sfr_bank_pkg::sfr_byte_t mask_r, mask_nxt;
  sfr_bank_pkg::sfr_byte_t setup_r, setup_nxt;
  sfr_bank_pkg::sfr_byte_t flag_r, flag_nxt;
  sfr_bank_pkg::buf_addr_t addr_r, addr_nxt;
  logic [CW-1:0]           blink_cnt_r, blink_cnt_nxt;
  logic                    blink_r, blink_nxt;

  always_comb begin
    mask_nxt      = mask_r;
    setup_nxt     = setup_r;
    addr_nxt      = addr_r;
    blink_cnt_nxt = blink_cnt_r;
    blink_nxt     = blink_r;
    if (wr_mask) begin
      mask_nxt = sfr_wdata;
    end
    if (wr_setup) begin
      setup_nxt = sfr_wdata;
    end
    // Set wins over a clear in the same cycle
    flag_nxt = (flag_r & ~(wr_flag ? sfr_wdata : 8'h00)) | pin_event_set;
    if (wr_low) begin
      addr_nxt[7:0] = sfr_wdata;
    end else if (wr_high) begin
      addr_nxt[10:8] = sfr_wdata[`BUF_HIGH_W-1:0];
    end else if (data_acc) begin
      // Natural 11-bit wrap carries low into high and 2047 back to 0
      addr_nxt = addr_r + 11'h001;
    end
    if (setup_r[`LED_BLINK_BIT]) begin
      if (blink_cnt_r == CW'(BLINK_HALF_CYCLES - 1)) begin
        blink_cnt_nxt = '0;
        blink_nxt     = ~blink_r;
      end else begin
        blink_cnt_nxt = blink_cnt_r + CW'(1);
      end
    end else begin
      blink_cnt_nxt = '0;
      blink_nxt     = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_r      <= `PIN_EVENT_MASK_RESET;
      setup_r     <= `UTILITY_SETUP_RESET;
      flag_r      <= 8'h00;
      addr_r      <= 11'h000;
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else if (ce) begin
      mask_r      <= mask_nxt;
      setup_r     <= setup_nxt;
      flag_r      <= flag_nxt;
      addr_r      <= addr_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_r     <= blink_nxt;
    end
  end

  // The read port always looks at the address that addr_r holds after this
  // edge, so the byte for a data port read already sits in the read
  // register when the read arrives, after an increment or an address write.
  // A write goes to the current address while the read port is one ahead,
  // so the two ports never meet and no write-through path is needed.
  // The price is a second address port on the buffer RAM.
  sfr_bank_pkg::sfr_byte_t ram_q;
  buffer_ram #(
    .AW (`BUF_ADDR_W),
    .DW (8)
  ) u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (data_wr),
    .waddr (addr_r),
    .raddr (addr_nxt),
    .wdata (sfr_wdata),
    .rdata (ram_q)
  );

  sfr_bank_pkg::sfr_byte_t rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    if (sfr_addr == `PIN_EVENT_MASK_ADDR) begin
      rdata_nxt = mask_r;
    end else if (sfr_addr == `UTILITY_SETUP_ADDR) begin
      rdata_nxt = setup_r;
    end else if (sfr_addr == `PIN_EVENT_FLAG_ADDR) begin
      rdata_nxt = flag_r;
    end else if (sfr_addr == `BUFFER_DATA_PORT_ADDR) begin
      rdata_nxt = ram_q;
    end else if (sfr_addr == `BUFFER_ADDR_LOW_ADDR) begin
      rdata_nxt = addr_r[7:0];
    end else if (sfr_addr == `BUFFER_ADDR_HIGH_ADDR) begin
      rdata_nxt = {5'h00, addr_r[10:8]};
    end
  end
  assign sfr_rdata = rdata_nxt;

  sfr_bank_pkg::sfr_byte_t out_nxt;
  logic [6:0]              pins_r;
  always_comb begin
    out_nxt[0] = |(flag_r & ~mask_r);
    out_nxt[1] = setup_r[`SCRATCH_MAP_BIT];
    out_nxt[2] = setup_r[`RX_SRC_BIT] ? 1'b0 : pin_s2_r[0];
    out_nxt[3] = setup_r[`TIMER0_SRC_BIT] ? timer0_alt_src : pin_s2_r[1];
    out_nxt[4] = setup_r[`TIMER1_SRC_BIT] ? timer1_alt_src : pin_s2_r[2];
    out_nxt[5] = setup_r[`PIN1_TX_BIT] ? port3_bit1 : general_pin_1_out;
    out_nxt[6] = setup_r[`PIN4_STROBE_BIT] ? disk_io_write_strobe : general_pin_4_out;
    out_nxt[7] = 1'b0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_r <= 7'h00;
    end else if (ce) begin
      pins_r <= out_nxt[6:0];
    end
  end

  assign core_external_irq_line = pins_r[0];
  assign scratch_map_select     = pins_r[1];
  assign external_data_space    = ~pins_r[1];
  assign port3_bit0             = pins_r[2];
  assign timer0_count_in        = pins_r[3];
  assign timer1_count_in        = pins_r[4];
  assign pin1_drive             = pins_r[5];
  assign pin4_drive             = pins_r[6];
  // Blink only replaces the level while pin 0 is an output
  assign pin0_drive = (setup_r[`LED_BLINK_BIT] && !general_pin_0_oe_n) ? blink_r
                                                                       : general_pin_0_out;
  assign pin_event_flags = flag_r;
endmodule // mcu_utility_sfr_bank

// ===== verif/mcu_utility_sfr_bank_props.sv
module mcu_utility_sfr_bank_props #(
  parameter int unsigned BLINK_HALF_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] pin_event_set,
  input wire logic       core_external_irq_line,
  input wire logic       scratch_map_select,
  input wire logic       external_data_space,
  input wire logic       general_pin_0_in,
  input wire logic       general_pin_0_oe_n,
  input wire logic       general_pin_0_out,
  input wire logic       general_pin_1_out,
  input wire logic       general_pin_2_in,
  input wire logic       general_pin_3_in,
  input wire logic       general_pin_4_out,
  input wire logic       disk_io_write_strobe,
  input wire logic       port3_bit1,
  input wire logic       timer0_count_in,
  input wire logic       timer1_count_in,
  input wire logic       pin1_drive,
  input wire logic       pin4_drive,
  input wire logic       port3_bit0,
  input wire logic       pin0_drive,
  input wire logic [7:0] pin_event_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0]  mask_h, setup_h;
  logic [10:0] addr_h;
  logic [31:0] run;
  logic        q, p0_q, bl_q;
  wire         wr = ce && sfr_wr;
  wire         bl = setup_h[5] && !general_pin_0_oe_n;
  wire   [7:0] live = pin_event_flags & ~mask_h;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_h  <= 8'hFF;
      setup_h <= 8'h00;
      addr_h  <= 11'h000;
      q       <= 1'b0;
      p0_q    <= 1'b0;
      bl_q    <= 1'b0;
      run     <= '1;
    end else begin
      bl_q <= bl;
      q    <= ce;
      p0_q <= pin0_drive;
      if (wr && sfr_addr == 8'h9C) mask_h <= sfr_wdata;
      if (wr && sfr_addr == 8'h9D) setup_h <= sfr_wdata;
      if (wr && sfr_addr == 8'hA1) addr_h[7:0] <= sfr_wdata;
      else if (wr && sfr_addr == 8'hA2) addr_h[10:8] <= sfr_wdata[2:0];
      else if (ce && (sfr_wr || sfr_rd) && sfr_addr == 8'h9F) addr_h <= addr_h + 11'h001;
      // Sentinel until the first toggle, so the start-up edge is not timed;
      // edges with the enable low do not advance the blink counter
      if (!bl || !bl_q) run <= '1;
      else if (pin0_drive != p0_q) run <= 32'h0;
      else if (run != '1 && q) run <= run + 32'h1;
    end
  end
  AST_IRQ_ON: assert property (q && $past(live) != 8'h00 |-> core_external_irq_line)
    else $error("irq low with unmasked flag");
  AST_IRQ_OFF: assert property (q && $past(live) == 8'h00 |-> !core_external_irq_line)
    else $error("irq high with all flags masked");
  AST_FLAG_CLR: assert property (wr && sfr_addr == 8'h9B && pin_event_set == 8'h00
    |=> (pin_event_flags & $past(sfr_wdata)) == 8'h00) else $error("flag not cleared");
  AST_MAP: assert property (q |-> scratch_map_select == $past(setup_h[7])
    && external_data_space == !scratch_map_select) else $error("map select wrong");
  AST_RX_ZERO: assert property (q && setup_h[0] && $past(setup_h[0]) |-> !port3_bit0)
    else $error("receive not held low");
  AST_RX_PIN: assert property ((!setup_h[0] && $stable(general_pin_0_in)) [*4]
    |-> port3_bit0 == general_pin_0_in) else $error("receive not from pin");
  AST_BLINK: assert property (bl && run != '1 |-> run < BLINK_HALF_CYCLES
    && (!$changed(pin0_drive) || run == BLINK_HALF_CYCLES - 1)) else $error("blink period");
  AST_ADDR_LO: assert property (ce && sfr_rd && sfr_addr == 8'hA1
    |-> sfr_rdata == addr_h[7:0]) else $error("low address wrong");
  AST_ADDR_HI: assert property (ce && sfr_rd && sfr_addr == 8'hA2
    |-> sfr_rdata == {5'h00, addr_h[10:8]}) else $error("high address wrong");
  AST_PIN4_MUX: assert property (q |-> pin4_drive == ($past(setup_h[4])
    ? $past(disk_io_write_strobe) : $past(general_pin_4_out))) else $error("pin 4 source wrong");
  AST_PIN1_MUX: assert property (q |-> pin1_drive == ($past(setup_h[1])
    ? $past(port3_bit1) : $past(general_pin_1_out))) else $error("pin 1 source wrong");
  AST_T0_PIN: assert property ((!setup_h[2] && $stable(general_pin_2_in)) [*4]
    |-> timer0_count_in == general_pin_2_in) else $error("timer0 not from pin 2");
  AST_T1_PIN: assert property ((!setup_h[3] && $stable(general_pin_3_in)) [*4]
    |-> timer1_count_in == general_pin_3_in) else $error("timer1 not from pin 3");
  AST_PIN0_PASS: assert property (!bl |-> pin0_drive == general_pin_0_out)
    else $error("pin 0 not passed through");
endmodule // mcu_utility_sfr_bank_props

bind mcu_utility_sfr_bank mcu_utility_sfr_bank_props #(
  .BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)
) u_props (.*);

// ===== verif/core_bus_model.sv
module core_bus_model (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // One bus cycle per call; entered right after a rising edge
  task automatic go(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    sfr_wr    <= w;
    sfr_rd    <= r;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go(1'b1, 1'b0, a, (a == 8'h9D) ? (d & 8'hBF) : d);
    if (a == 8'hA1 || a == 8'hA2) go(1'b0, 1'b0, ~a, ~d);
  endtask
  task automatic rd(input logic [7:0] a);
    go(1'b0, 1'b1, a, ~a);
  endtask
endmodule // core_bus_model

// ===== verif/mcu_utility_sfr_bank_tb.sv
module mcu_utility_sfr_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk, resetn, ce, sfr_wr, sfr_rd;
  logic [7:0]              addr, wdata, rdata, evt;
  logic [10:0]             rnd = 11'h000;
  sfr_bank_pkg::sfr_byte_t v, dat[4], exp_q[$];
  int                      n_mismatch = 0;
  int                      cmp_count = 0;
  core_bus_model u_core_bus_model (.clk(clk), .sfr_addr(addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(wdata));
  mcu_utility_sfr_bank #(.BLINK_HALF_CYCLES(4)) u_mcu_utility_sfr_bank (.clk(clk),
    .resetn(resetn), .ce(ce), .sfr_addr(addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .pin_event_set(evt), .core_external_irq_line(),
    .scratch_map_select(), .external_data_space(), .general_pin_0_in(rnd[0]),
    .general_pin_2_in(rnd[1]), .general_pin_3_in(rnd[2]), .general_pin_0_out(rnd[3]),
    .general_pin_0_oe_n(rnd[10]), .general_pin_1_out(rnd[4]), .general_pin_4_out(rnd[5]),
    .disk_io_write_strobe(rnd[6]), .port3_bit1(rnd[7]), .timer0_alt_src(rnd[8]),
    .timer1_alt_src(rnd[9]), .port3_bit0(), .timer0_count_in(), .timer1_count_in(),
    .pin0_drive(), .pin1_drive(), .pin4_drive(), .pin_event_flags());
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input sfr_bank_pkg::sfr_byte_t g, input sfr_bank_pkg::sfr_byte_t e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input sfr_bank_pkg::sfr_byte_t a, input sfr_bank_pkg::sfr_byte_t e);
    exp_q.push_back(e);
    u_core_bus_model.rd(a);
  endtask
  task automatic idle();
    u_core_bus_model.go(1'b0, 1'b0, 8'h00, 8'hFF);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pins change rarely so the synchroniser checks see quiet windows
  always @(posedge clk) if ($urandom_range(7) == 0) rnd <= 11'($urandom);
  always @(posedge clk) if (resetn && ce && sfr_rd) cmp(rdata, exp_q.pop_front());
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {resetn, evt, ce} = {1'b0, 8'h00, 1'b1};
    void'($urandom(32'hEA84));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(8'h9C, 8'hFF);
    rd(8'h9D, 8'h00);
    rd(8'hA2, 8'h00);
    rd(8'h9E, 8'h00);
    // A write while the enable is low must leave the mask as it was
    ce <= 1'b0;
    u_core_bus_model.wr(8'h9C, 8'h00);
    ce <= 1'b1;
    rd(8'h9C, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      u_core_bus_model.wr(8'h9D, v);
      repeat (6) idle();
      rd(8'h9D, v & 8'hBF);
    end
    u_core_bus_model.wr(8'hA1, 8'hFE);
    u_core_bus_model.wr(8'hA2, 8'hFF);
    rd(8'hA2, 8'h07);
    for (int i = 0; i < 4; i++) begin
      dat[i] = 8'($urandom);
      u_core_bus_model.wr(8'h9F, dat[i]);
    end
    rd(8'hA1, 8'h02);
    rd(8'hA2, 8'h00);
    u_core_bus_model.wr(8'hA1, 8'hFE);
    u_core_bus_model.wr(8'hA2, 8'h07);
    for (int i = 0; i < 4; i++) rd(8'h9F, dat[i]);
    v = 8'h01 << $urandom_range(7);
    evt <= v;
    idle();
    evt <= 8'h00;
    idle();
    rd(8'h9B, v);
    u_core_bus_model.wr(8'h9C, ~v);
    repeat (3) idle();
    u_core_bus_model.wr(8'h9B, v);
    rd(8'h9B, 8'h00);
    u_core_bus_model.wr(8'h9D, 8'h20);
    repeat (30) idle();
    if (exp_q.size() != 0) n_mismatch++;
    final_report();
  end
endmodule // mcu_utility_sfr_bank_tb
